/* shared/ief_pkg.sv */
/*
  Package for the interrupt enable and request-flag bank: register
  offsets, bit positions, reset values, vectors and service states.
  Assumes a classic Wishbone slave with 32-bit data, registers in the low
  byte of aligned words.
*/
package ief_pkg;

  localparam logic [7:0] IEF_OFF_PRIMARY   = 8'h00;
  localparam logic [7:0] IEF_OFF_SECONDARY = 8'h04;
  localparam logic [7:0] IEF_OFF_TERTIARY  = 8'h08;
  localparam logic [7:0] IEF_OFF_GROUP0    = 8'h0c;
  localparam logic [7:0] IEF_OFF_GROUP1    = 8'h10;
  localparam logic [7:0] IEF_OFF_VECTOR    = 8'h14;

  localparam logic [7:0] IEF_RST_REG = 8'h00;

  // Writable masks; unimplemented bits read as zero
  localparam logic [7:0] IEF_MASK_PRIMARY   = 8'h7f;
  localparam logic [7:0] IEF_MASK_SECONDARY = 8'hff;
  localparam logic [7:0] IEF_MASK_TERTIARY  = 8'h77;
  localparam logic [7:0] IEF_MASK_GROUP0    = 8'hff;
  localparam logic [7:0] IEF_MASK_GROUP1    = 8'h77;

  // Primary register bits
  localparam int IEF_P_EXT0_F  = 6;
  localparam int IEF_P_USB_F   = 5;
  localparam int IEF_P_CARD_F  = 4;
  localparam int IEF_P_EXT0_E  = 3;
  localparam int IEF_P_USB_E   = 2;
  localparam int IEF_P_CARD_E  = 1;
  localparam int IEF_P_MASTER  = 0;
  // Secondary register bits
  localparam int IEF_S_INS_F   = 7;
  localparam int IEF_S_TMR1_F  = 6;
  localparam int IEF_S_TMR0_F  = 5;
  localparam int IEF_S_EXT1_F  = 4;
  localparam int IEF_S_INS_E   = 3;
  localparam int IEF_S_TMR1_E  = 2;
  localparam int IEF_S_TMR0_E  = 1;
  localparam int IEF_S_EXT1_E  = 0;
  // Tertiary register bits
  localparam int IEF_T_GRP1_F  = 6;
  localparam int IEF_T_GRP0_F  = 5;
  localparam int IEF_T_CONV_F  = 4;
  localparam int IEF_T_GRP1_E  = 2;
  localparam int IEF_T_GRP0_E  = 1;
  localparam int IEF_T_CONV_E  = 0;
  // Group registers: flags in high nibble, enables in low nibble
  localparam int IEF_G_FLAG_LSB = 4;

  localparam int IEF_NUM_SRC = 10;
  localparam int IEF_NUM_EV  = 17;

  // Event input bit order
  localparam int IEF_EV_CARD   = 0;
  localparam int IEF_EV_USB    = 1;
  localparam int IEF_EV_EXT0   = 2;
  localparam int IEF_EV_EXT1   = 3;
  localparam int IEF_EV_TMR0   = 4;
  localparam int IEF_EV_TMR1   = 5;
  localparam int IEF_EV_CONV   = 6;
  localparam int IEF_EV_SER0   = 7;
  localparam int IEF_EV_RTC    = 8;
  localparam int IEF_EV_TBASE  = 9;
  localparam int IEF_EV_PERIPH = 10;
  localparam int IEF_EV_SER1   = 11;
  localparam int IEF_EV_TMR2   = 12;
  localparam int IEF_EV_TMR3   = 13;

  localparam logic [7:0] IEF_VEC_BASE = 8'h04;
  localparam logic [7:0] IEF_VEC_STEP = 8'h04;
  localparam logic [7:0] IEF_VEC_GRP0 = 8'h24;
  localparam logic [7:0] IEF_VEC_GRP1 = 8'h28;

  typedef enum logic [2:0] {
    IEF_ST_IDLE = 3'b001,
    IEF_ST_REQ  = 3'b010,
    IEF_ST_DONE = 3'b100
  } ief_state_t;

endpackage : ief_pkg

/* hw/ief_prio.sv */
/*
  Fixed-priority encoder: lowest index wins, vector from base upward.
  Assumes requests are already gated by enables.
*/
module ief_prio
  import ief_pkg::*;
(
  input  wire logic [IEF_NUM_SRC-1:0] req_i,
  output logic                        any_o,
  output logic [3:0]                  idx_o,
  output logic [7:0]                  vec_o
);

  function automatic logic [7:0] ief_vec(input logic [3:0] idx);
    ief_vec = IEF_VEC_BASE + 8'(idx) * IEF_VEC_STEP;
  endfunction : ief_vec

  always_comb
  begin
    any_o = 1'b0;
    idx_o = 4'h0;
    for (int i = IEF_NUM_SRC - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        any_o = 1'b1;
        idx_o = 4'(i);
      end
    end
    vec_o = ief_vec(idx_o);
  end

endmodule : ief_prio

/* hw/ief_edge.sv */
/*
  Rising-edge detector for the card-detect change status bit.
  Assumes the status bit is synchronous to clk_i.
*/
module ief_edge
  import ief_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lvl_i,
  output logic      rise_o
);

  logic lvl_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lvl_q <= 1'b0;
    else
      lvl_q <= lvl_i;
  end

  assign rise_o = lvl_i & ~lvl_q;

endmodule : ief_edge

/* hw/ief_bank.sv */
/*
  Interrupt enable and request-flag bank with Wishbone register access
  and a request/acknowledge handshake to the processor core.
  Assumes one clock, synchronous events and a core that pulses irq_ack_i
  once for each accepted request.
*/
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
// Functional notes
// RULE1 - Master enable clear blocks all service
// RULE2 - Source event sets its request flag
// RULE3 - Per-source enable gates service request
// RULE4 - Primary register bit layout
// RULE5 - Secondary register bit layout
// RULE6 - Card-detect change sets insertion flag
// RULE7 - Tertiary register layout, bits 7,3 zero
// RULE8 - Group 0 register layout
// RULE9 - Group 1 register layout, bits 7,3 zero
// RULE10 - Acceptance clears master enable
// RULE11 - Fixed priority, vectors 04h step four
// RULE12 - Group members share vectors 24h, 28h
// RULE13 - Servicing clears group flag only
// RULE14 - Enabled pending member sets group flag
// RULE15 - Reset clears all five registers
module ief_bank
  import ief_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [7:0]                 adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic [IEF_NUM_EV-1:0]      event_i,
  input  wire logic                       card_detect_change_i,
  output logic                            irq_req_o,
  output logic      [7:0]                 irq_vector_o,
  input  wire logic                       irq_ack_i
);

  typedef struct packed {
    logic [7:0]  prim;
    logic [7:0]  sec;
    logic [7:0]  ter;
    logic [7:0]  grp0;
    logic [7:0]  grp1;
    logic [31:0] rdat;
    logic        ack;
    logic        req;
    logic [7:0]  vec;
    logic [3:0]  idx;
    ief_state_t  st;
  } ief_regs_t;

  ief_regs_t r_q;
  ief_regs_t r_d;

  logic                   ins_rise;
  logic [IEF_NUM_SRC-1:0] pend;
  logic                   any_pend;
  logic [3:0]             win_idx;
  logic [7:0]             win_vec;

  ief_edge u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .lvl_i  (card_detect_change_i),
    .rise_o (ins_rise)
  );

  // Enabled pending sources in priority order
  always_comb
  begin
    pend[0] = r_q.prim[IEF_P_CARD_F] & r_q.prim[IEF_P_CARD_E]; // [RULE3]
    pend[1] = r_q.prim[IEF_P_USB_F]  & r_q.prim[IEF_P_USB_E];
    pend[2] = r_q.prim[IEF_P_EXT0_F] & r_q.prim[IEF_P_EXT0_E];
    pend[3] = r_q.sec[IEF_S_EXT1_F]  & r_q.sec[IEF_S_EXT1_E];
    pend[4] = r_q.sec[IEF_S_TMR0_F]  & r_q.sec[IEF_S_TMR0_E];
    pend[5] = r_q.sec[IEF_S_TMR1_F]  & r_q.sec[IEF_S_TMR1_E];
    pend[6] = r_q.sec[IEF_S_INS_F]   & r_q.sec[IEF_S_INS_E];
    pend[7] = r_q.ter[IEF_T_CONV_F]  & r_q.ter[IEF_T_CONV_E];
    pend[8] = r_q.ter[IEF_T_GRP0_F]  & r_q.ter[IEF_T_GRP0_E]; // [RULE12]
    pend[9] = r_q.ter[IEF_T_GRP1_F]  & r_q.ter[IEF_T_GRP1_E];
  end

  ief_prio u_prio (
    .req_i (pend),
    .any_o (any_pend),
    .idx_o (win_idx),
    .vec_o (win_vec)
  );

  // Byte-lane-0 write with hardware sets taking precedence afterwards
  function automatic logic [7:0] ief_wr(input logic [7:0] cur,
                                        input logic [7:0] wd,
                                        input logic [7:0] mask,
                                        input logic       hit);
    ief_wr = hit ? (wd & mask) : cur;
  endfunction : ief_wr

  function automatic logic ief_grp_any(input logic [7:0] g);
    ief_grp_any = |(g[7:4] & g[3:0]);
  endfunction : ief_grp_any

  logic       bus_req;
  logic       wr_hit;
  logic [7:0] wd;

  assign bus_req = cyc_i & stb_i & ~r_q.ack;
  assign wr_hit  = bus_req & we_i & sel_i[0];
  assign wd      = dat_i[7:0];

  always_comb
  begin
    r_d     = r_q;
    r_d.ack = bus_req;
    r_d.rdat = 32'h0;

    // Register writes
    if (wr_hit && adr_i == IEF_OFF_PRIMARY)
      r_d.prim = ief_wr(r_q.prim, wd, IEF_MASK_PRIMARY, 1'b1); // [RULE4]
    else if (wr_hit && adr_i == IEF_OFF_SECONDARY)
      r_d.sec = ief_wr(r_q.sec, wd, IEF_MASK_SECONDARY, 1'b1); // [RULE5]
    else if (wr_hit && adr_i == IEF_OFF_TERTIARY)
      r_d.ter = ief_wr(r_q.ter, wd, IEF_MASK_TERTIARY, 1'b1); // [RULE7]
    else if (wr_hit && adr_i == IEF_OFF_GROUP0)
      r_d.grp0 = ief_wr(r_q.grp0, wd, IEF_MASK_GROUP0, 1'b1); // [RULE8]
    else if (wr_hit && adr_i == IEF_OFF_GROUP1)
      r_d.grp1 = ief_wr(r_q.grp1, wd, IEF_MASK_GROUP1, 1'b1); // [RULE9]

    // Reads; unmapped addresses read zero but still acknowledge
    if (bus_req && !we_i)
    begin
      if (adr_i == IEF_OFF_PRIMARY)
        r_d.rdat = {24'h0, r_q.prim};
      else if (adr_i == IEF_OFF_SECONDARY)
        r_d.rdat = {24'h0, r_q.sec};
      else if (adr_i == IEF_OFF_TERTIARY)
        r_d.rdat = {24'h0, r_q.ter};
      else if (adr_i == IEF_OFF_GROUP0)
        r_d.rdat = {24'h0, r_q.grp0};
      else if (adr_i == IEF_OFF_GROUP1)
        r_d.rdat = {24'h0, r_q.grp1};
      else if (adr_i == IEF_OFF_VECTOR)
        r_d.rdat = {23'h0, r_q.req, r_q.vec};
    end

    // Service handshake
    case (r_q.st)
      IEF_ST_IDLE:
      begin
        if (any_pend && r_q.prim[IEF_P_MASTER]) // [RULE1]
        begin
          r_d.req = 1'b1;
          r_d.vec = win_vec; // [RULE11]
          r_d.idx = win_idx;
          r_d.st  = IEF_ST_REQ;
        end
      end
      IEF_ST_REQ:
      begin
        if (irq_ack_i)
        begin
          r_d.req = 1'b0;
          r_d.st  = IEF_ST_DONE;
          r_d.prim[IEF_P_MASTER] = 1'b0; // [RULE10]
          // Serviced flag is cleared; group members stay set
          case (r_q.idx)
            4'd0: r_d.prim[IEF_P_CARD_F] = 1'b0;
            4'd1: r_d.prim[IEF_P_USB_F]  = 1'b0;
            4'd2: r_d.prim[IEF_P_EXT0_F] = 1'b0;
            4'd3: r_d.sec[IEF_S_EXT1_F]  = 1'b0;
            4'd4: r_d.sec[IEF_S_TMR0_F]  = 1'b0;
            4'd5: r_d.sec[IEF_S_TMR1_F]  = 1'b0;
            4'd6: r_d.sec[IEF_S_INS_F]   = 1'b0;
            4'd7: r_d.ter[IEF_T_CONV_F]  = 1'b0;
            4'd8: r_d.ter[IEF_T_GRP0_F]  = 1'b0; // [RULE13]
            default: r_d.ter[IEF_T_GRP1_F] = 1'b0; // [RULE13]
          endcase
        end
        else if (!r_q.prim[IEF_P_MASTER] || !any_pend)
        begin
          // Software withdrew permission before the core took it
          r_d.req = 1'b0;
          r_d.st  = IEF_ST_IDLE;
        end
        else
        begin
          r_d.vec = win_vec;
          r_d.idx = win_idx;
        end
      end
      IEF_ST_DONE:
        r_d.st = IEF_ST_IDLE;
      default:
      begin
        r_d.req = 1'b0;
        r_d.st  = IEF_ST_IDLE;
      end
    endcase

    // Hardware sets last, so an event beats a same-cycle clear
    if (event_i[IEF_EV_CARD])  r_d.prim[IEF_P_CARD_F] = 1'b1; // [RULE2]
    if (event_i[IEF_EV_USB])   r_d.prim[IEF_P_USB_F]  = 1'b1;
    if (event_i[IEF_EV_EXT0])  r_d.prim[IEF_P_EXT0_F] = 1'b1;
    if (event_i[IEF_EV_EXT1])  r_d.sec[IEF_S_EXT1_F]  = 1'b1;
    if (event_i[IEF_EV_TMR0])  r_d.sec[IEF_S_TMR0_F]  = 1'b1;
    if (event_i[IEF_EV_TMR1])  r_d.sec[IEF_S_TMR1_F]  = 1'b1;
    if (ins_rise)              r_d.sec[IEF_S_INS_F]   = 1'b1; // [RULE6]
    if (event_i[IEF_EV_CONV])  r_d.ter[IEF_T_CONV_F]  = 1'b1;
    if (event_i[IEF_EV_SER0])  r_d.grp0[IEF_G_FLAG_LSB + 0] = 1'b1;
    if (event_i[IEF_EV_RTC])   r_d.grp0[IEF_G_FLAG_LSB + 1] = 1'b1;
    if (event_i[IEF_EV_TBASE]) r_d.grp0[IEF_G_FLAG_LSB + 2] = 1'b1;
    if (event_i[IEF_EV_PERIPH]) r_d.grp0[IEF_G_FLAG_LSB + 3] = 1'b1;
    if (event_i[IEF_EV_SER1])  r_d.grp1[IEF_G_FLAG_LSB + 0] = 1'b1;
    if (event_i[IEF_EV_TMR2])  r_d.grp1[IEF_G_FLAG_LSB + 1] = 1'b1;
    if (event_i[IEF_EV_TMR3])  r_d.grp1[IEF_G_FLAG_LSB + 2] = 1'b1;
    // Shared flag follows enabled members from the stored state; a
    // still-pending member keeps it set over the clear at acceptance
    if (ief_grp_any(r_q.grp0) && r_q.st != IEF_ST_DONE)
      r_d.ter[IEF_T_GRP0_F] = 1'b1; // [RULE14]
    if (ief_grp_any(r_q.grp1) && r_q.st != IEF_ST_DONE)
      r_d.ter[IEF_T_GRP1_F] = 1'b1; // [RULE14]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_q      <= '0; // [RULE15]
      r_q.prim <= IEF_RST_REG;
      r_q.st   <= IEF_ST_IDLE;
    end
    else
      r_q <= r_d;
  end

  assign dat_o        = r_q.rdat;
  assign ack_o        = r_q.ack;
  assign irq_req_o    = r_q.req;
  assign irq_vector_o = r_q.vec;

  // Assertions
  sequence s_accept;
    r_q.st == IEF_ST_REQ && irq_ack_i;
  endsequence

  a_master_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
    $rose(irq_req_o) |-> $past(r_q.prim[IEF_P_MASTER]))
    else $error("request raised with master enable clear");
  a_event_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    event_i[IEF_EV_TMR0] |=> r_q.sec[IEF_S_TMR0_F])
    else $error("timer 0 event did not set its flag");
  a_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    $rose(irq_req_o) && irq_vector_o == IEF_VEC_BASE
      |-> $past(r_q.prim[IEF_P_CARD_E]))
    else $error("disabled card source requested");
  a_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    r_q.ter[7] == 1'b0 && r_q.ter[3] == 1'b0 && r_q.grp1[7] == 1'b0
      && r_q.grp1[3] == 1'b0 && r_q.prim[7] == 1'b0)
    else $error("unimplemented bit set");
  a_insert_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
    ins_rise |=> r_q.sec[IEF_S_INS_F])
    else $error("card change did not set insertion flag");
  a_accept_clr: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    s_accept |=> !r_q.prim[IEF_P_MASTER] && !irq_req_o)
    else $error("master enable not cleared on acceptance");
  a_prio_vec: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    $rose(irq_req_o) |-> irq_vector_o == IEF_VEC_BASE
      + 8'($past(win_idx)) * IEF_VEC_STEP)
    else $error("vector does not match winning source");
  a_group_vec: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    irq_req_o && irq_vector_o == IEF_VEC_GRP0 |-> r_q.ter[IEF_T_GRP0_F])
    else $error("group 0 vector without group flag");
  a_group_keep: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
    s_accept and (r_q.idx == 4'd8 && r_q.grp0[4] && !wr_hit)
      |=> r_q.grp0[4])
    else $error("member flag cleared by service");
  a_group_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
    r_q.grp1[4] && r_q.grp1[0] && r_q.st == IEF_ST_IDLE
      |=> r_q.ter[IEF_T_GRP1_F])
    else $error("group 1 flag not set");

endmodule : ief_bank

/* bench/ief_core_model.sv */
/*
  Processor core stand-in: takes service requests after a chosen delay,
  pulses one acknowledge per request and keeps the vector it took.
  Assumes the bank holds its request until the acknowledge edge.
*/
module ief_core_model
  import ief_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       irq_req_i,
  input  wire logic [7:0] irq_vector_i,
  input  wire logic [3:0] lat_i,
  output logic            irq_ack_o,
  output logic [7:0]      vec_o,
  output logic [7:0]      n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;

  // Never acknowledges twice in a row: the bank needs its dead cycle
  always_ff @(posedge clk_i)
  begin
    irq_ack_o <= 1'b0;
    if (rst_i)
    begin
      wait_q <= 4'h0;
      vec_o  <= 8'h00;
      n_o    <= 8'h00;
    end
    else if (irq_req_i && !irq_ack_o)
    begin
      wait_q <= (wait_q == lat_i) ? 4'h0 : wait_q + 4'h1;
      if (wait_q == lat_i)
      begin
        irq_ack_o <= 1'b1;
        vec_o     <= irq_vector_i;
        n_o       <= n_o + 8'h01;
      end
    end
    else
      wait_q <= 4'h0;
  end
endmodule : ief_core_model

/* bench/ief_bank_tb.sv */
/*
  Self-checking bench for the interrupt enable and flag bank.
  Assumes the core model answers requests; registers sit in word low bytes.
*/
module ief_bank_tb;
  import ief_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc_i     = 1'b0;
  logic        stb_i     = 1'b0;
  logic        we_i      = 1'b0;
  logic [7:0]  adr_i     = 8'h00;
  logic [31:0] dat_i     = 32'h0;
  logic [16:0] event_i   = 17'h0;
  logic        cdc_i     = 1'b0;
  logic [3:0]  lat       = 4'h0;
  logic [31:0] dat_o;
  logic [31:0] d;
  logic        ack_o;
  logic        irq_req_o;
  logic        irq_ack_i;
  logic [7:0]  irq_vector_o;
  logic [7:0]  vec;
  logic [7:0]  acks;
  int          err_total = 0;
  int          checks    = 0;
  logic [7:0]  offs[6] = '{IEF_OFF_PRIMARY, IEF_OFF_SECONDARY,
    IEF_OFF_TERTIARY, IEF_OFF_GROUP0, IEF_OFF_GROUP1, 8'h18};
  logic [7:0]  mk[5] = '{8'h7e, 8'hff, 8'h77, 8'hff, 8'h77};

  ief_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
    .card_detect_change_i(cdc_i), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_ack_i(irq_ack_i));

  ief_core_model u_core (.clk_i(clk_i), .rst_i(rst_i),
    .irq_req_i(irq_req_o), .irq_vector_i(irq_vector_o), .lat_i(lat),
    .irq_ack_o(irq_ack_i), .vec_o(vec), .n_o(acks));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Ack is judged at the rising edge that samples it; the request is
  // released by non-blocking assignment at that same edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    chk({31'h0, ack_o}, 32'h1);
    d = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rdc

  task automatic ev(input logic [16:0] m);
    @(posedge clk_i);
    event_i <= m;
    @(posedge clk_i);
    event_i <= 17'h0;
  endtask : ev

  task automatic quiet();
    repeat (8)
    begin
      @(negedge clk_i);
      chk({31'h0, irq_req_o}, 32'h0);
    end
  endtask : quiet

  // Read-modify-write keeps pending flags while setting the master bit
  task automatic serve(input logic [7:0] exp);
    logic [7:0] n0;
    int         k;
    n0 = acks;
    k  = 0;
    bus(1'b0, IEF_OFF_PRIMARY, 32'h0);
    wr(IEF_OFF_PRIMARY, d | 32'h1);
    while (acks == n0 && k < 40)
    begin
      @(negedge clk_i);
      k++;
    end
    chk({24'h0, vec}, {24'h0, exp});
  endtask : serve

  task automatic t_reset();
    foreach (offs[i]) rdc(offs[i], 32'h0);
    rdc(IEF_OFF_VECTOR, 32'h0);
  endtask : t_reset

  task automatic t_masks();
    for (int i = 0; i < 5; i++) wr(offs[i], (i == 0) ? 32'h7e : 32'hff);
    wr(8'h18, 32'hff);
    foreach (mk[i]) rdc(offs[i], {24'h0, mk[i]});
    rdc(8'h18, 32'h0);
    quiet();
    for (int i = 4; i >= 0; i--) wr(offs[i], 32'h0);
    foreach (mk[i]) rdc(offs[i], 32'h0);
  endtask : t_masks

  task automatic t_timer();
    wr(IEF_OFF_SECONDARY, 32'h02);
    ev(17'h1 << IEF_EV_TMR0);
    rdc(IEF_OFF_SECONDARY, 32'h22);
    quiet();
    serve(8'h14);
    rdc(IEF_OFF_PRIMARY, 32'h0);
    rdc(IEF_OFF_SECONDARY, 32'h02);
  endtask : t_timer

  task automatic t_disabled();
    wr(IEF_OFF_SECONDARY, 32'h0);
    ev(17'h1 << IEF_EV_EXT1);
    rdc(IEF_OFF_SECONDARY, 32'h10);
    wr(IEF_OFF_PRIMARY, 32'h1);
    quiet();
    wr(IEF_OFF_PRIMARY, 32'h0);
    wr(IEF_OFF_SECONDARY, 32'h0);
  endtask : t_disabled

  // All sources pend at once and are served one by one in priority order
  task automatic t_prio();
    wr(IEF_OFF_PRIMARY, 32'h0e);
    wr(IEF_OFF_SECONDARY, 32'h0f);
    wr(IEF_OFF_TERTIARY, 32'h07);
    wr(IEF_OFF_GROUP0, 32'h0f);
    wr(IEF_OFF_GROUP1, 32'h07);
    @(posedge clk_i);
    cdc_i <= 1'b1;
    ev(17'h3fff);
    for (int i = 0; i < 10; i++)
    begin
      lat <= (i % 2) ? 4'h5 : 4'h0;
      serve(8'(4 * (i + 1)));
      if (i == 8)
      begin
        rdc(IEF_OFF_GROUP0, 32'hff);
        wr(IEF_OFF_GROUP0, 32'h0f);
        wr(IEF_OFF_TERTIARY, 32'h47);
      end
    end
    rdc(IEF_OFF_GROUP1, 32'h77);
    cdc_i <= 1'b0;
  endtask : t_prio

  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_masks();
    t_timer();
    t_disabled();
    t_prio();
    conclude();
  end

  // The whole sequence needs well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule : ief_bank_tb
